// ==== hw/btir_defines.svh ====
`ifndef BTIR_DEFINES_SVH
`define BTIR_DEFINES_SVH
// vector addresses
`define BTIR_VEC_RESET 10'h000
`define BTIR_VEC_DONE 10'h002
`define BTIR_VEC_EMPTY 10'h004
// flag positions in the flag vector
`define BTIR_F_EMPTY 0
`define BTIR_F_DONE 2
// slot control: count_hi sits in bits 6:5
`define BTIR_CNT_HI_POS 6
`define BTIR_CNT_RST 10'h000
`define BTIR_LOW_RST 8'h00
// core sequencing, in clock cycles
`define BTIR_ENTRY_CYC 3'h4
`define BTIR_JUMP_CYC 3'h2
`define BTIR_RET_CYC 3'h4
`define BTIR_IO_ACC_CYC 2'h2
`define BTIR_POR_CYC 1000000
// reset word opcodes
`define BTIR_RELATIVE_JUMP_OP_OP 4'hC
`define BTIR_JMP_OP 7'h4A
`define BTIR_JMP_LOW 3'h6
`endif

// ==== hw/btir_pkg.sv ====
package btir_pkg;
   typedef enum logic [1:0] {
      BTIR_OFF = 2'h0,
      BTIR_TX = 2'h1,
      BTIR_RX = 2'h2,
      BTIR_GEN = 2'h3
   } btir_mode_t;
   // slot control fields, msb first
   typedef struct packed {
      logic [1:0] count_hi;
      btir_mode_t mode;
      logic en_done;
      logic en_empty;
      logic data;
   } btir_ctrl_t;
   typedef enum logic [2:0] {
      BTIR_IQ_IDLE = 3'h0,
      BTIR_IQ_ENTRY = 3'h1,
      BTIR_IQ_JUMP = 3'h3,
      BTIR_IQ_HANDLER = 3'h2,
      BTIR_IQ_RETURN = 3'h6,
      BTIR_IQ_ONE = 3'h7
   } btir_iq_t;
   typedef enum logic [2:0] {
      BTIR_RS_POR = 3'h0,
      BTIR_RS_CHK = 3'h1,
      BTIR_RS_RUN = 3'h3,
      BTIR_RS_BTN = 3'h2,
      BTIR_RS_PIN = 3'h6,
      BTIR_RS_NOPROG = 3'h7
   } btir_rs_t;
endpackage : btir_pkg

// ==== hw/btir_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "btir_defines.svh"
module btir_timer #(
   parameter int POR_DELAY = `BTIR_POR_CYC
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // software access
   input wire logic slot_count_low_we,
   input wire logic [7:0] slot_count_low_wdata,
   input wire logic slot_control_we,
   input wire btir_pkg::btir_ctrl_t slot_control_wdata,
   input wire logic [2:0] power_clock_control,
   input wire logic [2:0] flag_clr,
   output logic [7:0] slot_count_low_q,
   output btir_pkg::btir_ctrl_t slot_control_q,
   output logic [2:0] flags_q,
   // pins
   input wire logic pulse_input_pin,
   input wire logic reset_pin_n,
   input wire logic brownout,
   input wire logic button_press,
   output logic tx_key,
   // core sequencing
   input wire logic global_int_en,
   input wire logic instr_boundary,
   input wire logic instr_retired,
   input wire logic reti_req,
   input wire logic [15:0] reset_word,
   input wire logic reset_word_valid,
   output logic push_pc,
   output logic pop_pc,
   output logic fetch_vector,
   output logic [9:0] vector_addr,
   output logic core_run,
   // reset control
   input wire logic watchdog_rst,
   input wire logic button_rst_req,
   output logic io_reset,
   output logic serial_prog_mode,
   output logic serial_io_ready,
   output logic no_program
);
   localparam int PW = $clog2(POR_DELAY + 1);
   localparam logic [3:0] SYNC_RST = 4'h4;

   ////////////////////////////////////////////////////////////////
   // pin synchronisers: pulse, reset pin, brownout, button
   logic [3:0] pins;
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   assign pins = {pulse_input_pin, reset_pin_n, brownout, button_press};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               sync1_r[gi] <= SYNC_RST[gi];
               sync2_r[gi] <= SYNC_RST[gi];
            end else if (clk_en) begin
               sync1_r[gi] <= pins[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate
   logic pulse_s, pin_low, bo_s, btn_s;
   assign pulse_s = sync2_r[3];
   assign pin_low = ~sync2_r[2];
   assign bo_s = sync2_r[1];
   assign btn_s = sync2_r[0];

   ////////////////////////////////////////////////////////////////
   // reset sequencer
   btir_pkg::btir_rs_t rs_r;
   logic [PW-1:0] por_cnt_r;
   logic [1:0] acc_cnt_r;
   logic jump_word;
   // only a relative or absolute jump counts as a program
   assign jump_word = (reset_word[15:12] == `BTIR_RELATIVE_JUMP_OP_OP) ||
                      (reset_word[15:9] == `BTIR_JMP_OP &&
                       reset_word[3:1] == `BTIR_JMP_LOW);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rs_r <= btir_pkg::BTIR_RS_POR;
      end else if (clk_en) begin
         if (pin_low || bo_s) begin
            rs_r <= btir_pkg::BTIR_RS_PIN;
         end else if (watchdog_rst) begin
            rs_r <= btir_pkg::BTIR_RS_CHK;
         end else begin
            case (rs_r)
               btir_pkg::BTIR_RS_POR: begin
                  if (por_cnt_r == PW'(POR_DELAY - 1)) begin
                     rs_r <= btir_pkg::BTIR_RS_CHK;
                  end
               end
               btir_pkg::BTIR_RS_CHK: begin
                  if (reset_word_valid) begin
                     rs_r <= jump_word ? btir_pkg::BTIR_RS_RUN
                                       : btir_pkg::BTIR_RS_NOPROG;
                  end
               end
               btir_pkg::BTIR_RS_RUN: begin
                  if (button_rst_req) begin
                     rs_r <= btir_pkg::BTIR_RS_BTN;
                  end
               end
               btir_pkg::BTIR_RS_BTN: begin
                  if (btn_s) begin
                     rs_r <= btir_pkg::BTIR_RS_CHK;
                  end
               end
               btir_pkg::BTIR_RS_PIN: rs_r <= btir_pkg::BTIR_RS_CHK;
               btir_pkg::BTIR_RS_NOPROG: rs_r <= btir_pkg::BTIR_RS_NOPROG;
               default: rs_r <= btir_pkg::BTIR_RS_POR;
            endcase
         end
      end
   end
   // power-on delay counter, only runs in the power-on state
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         por_cnt_r <= '0;
      end else if (clk_en && rs_r == btir_pkg::BTIR_RS_POR) begin
         por_cnt_r <= por_cnt_r + PW'(1);
      end
   end
   // serial access opens two clocks into a pin reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_cnt_r <= 2'h0;
      end else if (clk_en) begin
         if (rs_r != btir_pkg::BTIR_RS_PIN || !pin_low) begin
            acc_cnt_r <= 2'h0;
         end else if (acc_cnt_r != `BTIR_IO_ACC_CYC) begin
            acc_cnt_r <= acc_cnt_r + 2'h1;
         end
      end
   end
   // button reset leaves io alone, so it is absent here
   assign io_reset = rs_r == btir_pkg::BTIR_RS_POR ||
                     rs_r == btir_pkg::BTIR_RS_PIN || watchdog_rst;
   assign serial_prog_mode = rs_r == btir_pkg::BTIR_RS_PIN && pin_low;
   assign serial_io_ready = acc_cnt_r == `BTIR_IO_ACC_CYC;
   assign core_run = rs_r == btir_pkg::BTIR_RS_RUN;
   assign no_program = rs_r == btir_pkg::BTIR_RS_NOPROG;

   ////////////////////////////////////////////////////////////////
   // slot registers and prescaler
   btir_pkg::btir_ctrl_t ctrl_r;
   logic [7:0] low_r;
   logic [7:0] presc_r;
   logic [7:0] presc_mask;
   logic [9:0] count_val;
   logic [9:0] cnt_r;
   logic [2:0] flags_r;
   logic buf_full_r, done_lat_r, key_r, pulse_d_r, tick;
   btir_pkg::btir_mode_t mode_d_r;
   assign count_val = {ctrl_r.count_hi, low_r};
   // period is 2^sel clocks, mirroring the core clock divider
   assign presc_mask = 8'((8'h01 << power_clock_control) - 8'h01);
   assign tick = (presc_r & presc_mask) == presc_mask;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         presc_r <= 8'h00;
      end else if (clk_en) begin
         if (io_reset || ctrl_r.mode == btir_pkg::BTIR_OFF) begin
            presc_r <= 8'h00;
         end else begin
            presc_r <= tick ? 8'h00 : presc_r + 8'h01;
         end
      end
   end

   // timer events
   logic is_tx, is_rx, is_gen, at_zero, take, empty_exp, gen_exp;
   logic edge_seen, mode_chg;
   assign is_tx = ctrl_r.mode == btir_pkg::BTIR_TX;
   assign is_rx = ctrl_r.mode == btir_pkg::BTIR_RX;
   assign is_gen = ctrl_r.mode == btir_pkg::BTIR_GEN;
   assign mode_chg = ctrl_r.mode != mode_d_r;
   assign at_zero = cnt_r == `BTIR_CNT_RST;
   assign take = is_tx && !mode_chg && tick && at_zero && buf_full_r;
   assign empty_exp = is_tx && !mode_chg && tick && at_zero &&
                      !buf_full_r && !done_lat_r;
   assign gen_exp = is_gen && !mode_chg && tick && at_zero;
   assign edge_seen = is_rx && (pulse_s != pulse_d_r);

   // count down for transmit and generic, up for receive
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= `BTIR_CNT_RST;
         mode_d_r <= btir_pkg::BTIR_OFF;
         pulse_d_r <= 1'b0;
      end else if (clk_en) begin
         mode_d_r <= ctrl_r.mode;
         pulse_d_r <= pulse_s;
         if (io_reset) begin
            cnt_r <= `BTIR_CNT_RST;
         end else if (mode_chg) begin
            // generic waits a full interval first
            cnt_r <= is_gen ? count_val : `BTIR_CNT_RST;
         end else if (is_rx) begin
            if (edge_seen) begin
               cnt_r <= `BTIR_CNT_RST;
            end else if (tick && cnt_r != 10'h3FF) begin
               cnt_r <= cnt_r + 10'h001;
            end
         end else if (is_tx || is_gen) begin
            if (tick) begin
               cnt_r <= at_zero ? ((take || is_gen) ? count_val : cnt_r)
                                : cnt_r - 10'h001;
            end
         end
      end
   end

   // software writes; a receive capture beats a same-cycle write
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= '0;
         low_r <= `BTIR_LOW_RST;
      end else if (clk_en) begin
         if (io_reset) begin
            ctrl_r <= '0;
            low_r <= `BTIR_LOW_RST;
         end else begin
            if (slot_control_we) begin
               ctrl_r <= slot_control_wdata;
            end
            if (slot_count_low_we) begin
               low_r <= slot_count_low_wdata;
            end
            if (edge_seen) begin
               low_r <= cnt_r[7:0];
               ctrl_r.count_hi <= cnt_r[9:8];
               ctrl_r.data <= pulse_s;
            end
         end
      end
   end

   // the write that enters transmit mode already carries the first bit,
   // otherwise the first slot would report done with data still pending
   logic tx_wr;
   assign tx_wr = slot_control_we && slot_control_wdata.mode == btir_pkg::BTIR_TX;
   // buffer state; a new bit written in the take cycle survives
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         buf_full_r <= 1'b0;
         done_lat_r <= 1'b0;
         key_r <= 1'b0;
      end else if (clk_en) begin
         if (io_reset || (!is_tx && !tx_wr)) begin
            buf_full_r <= 1'b0;
            done_lat_r <= 1'b0;
            key_r <= 1'b0;
         end else begin
            buf_full_r <= slot_control_we || (buf_full_r && !take);
            if (take) begin
               key_r <= ctrl_r.data;
               done_lat_r <= 1'b0;
            end else if (empty_exp) begin
               done_lat_r <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // flags: hardware set wins over software clear or vector ack
   logic [2:0] flag_set, flag_ack;
   assign flag_set = {empty_exp || gen_exp, 1'b0, take};
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags_r <= 3'h0;
      end else if (clk_en) begin
         if (io_reset) begin
            flags_r <= 3'h0;
         end else begin
            flags_r <= flag_set | (flags_r & ~(flag_clr | flag_ack));
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // interrupt sequencer
   btir_pkg::btir_iq_t iq_r;
   logic [2:0] cyc_r;
   logic [9:0] vec_r;
   logic pend_empty, pend_done, irq_req, start;
   assign pend_empty = flags_r[`BTIR_F_EMPTY] && ctrl_r.en_empty;
   assign pend_done = flags_r[`BTIR_F_DONE] && ctrl_r.en_done;
   assign irq_req = global_int_en && (pend_empty || pend_done);
   assign start = core_run && iq_r == btir_pkg::BTIR_IQ_IDLE &&
                  irq_req && instr_boundary;
   // lower vector wins, so done is served before empty
   assign flag_ack = start ? (pend_done ? 3'h4 : 3'h1) : 3'h0;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         iq_r <= btir_pkg::BTIR_IQ_IDLE;
         cyc_r <= 3'h0;
      end else if (clk_en) begin
         cyc_r <= cyc_r + 3'h1;
         if (!core_run) begin
            iq_r <= btir_pkg::BTIR_IQ_IDLE;
         end else begin
            case (iq_r)
               btir_pkg::BTIR_IQ_IDLE: begin
                  if (start) begin
                     iq_r <= btir_pkg::BTIR_IQ_ENTRY;
                     cyc_r <= 3'h0;
                  end
               end
               btir_pkg::BTIR_IQ_ENTRY: begin
                  if (cyc_r == `BTIR_ENTRY_CYC - 3'h1) begin
                     iq_r <= btir_pkg::BTIR_IQ_JUMP;
                     cyc_r <= 3'h0;
                  end
               end
               btir_pkg::BTIR_IQ_JUMP: begin
                  if (cyc_r == `BTIR_JUMP_CYC - 3'h1) begin
                     iq_r <= btir_pkg::BTIR_IQ_HANDLER;
                  end
               end
               btir_pkg::BTIR_IQ_HANDLER: begin
                  if (reti_req) begin
                     iq_r <= btir_pkg::BTIR_IQ_RETURN;
                     cyc_r <= 3'h0;
                  end
               end
               btir_pkg::BTIR_IQ_RETURN: begin
                  if (cyc_r == `BTIR_RET_CYC - 3'h1) begin
                     iq_r <= btir_pkg::BTIR_IQ_ONE;
                  end
               end
               btir_pkg::BTIR_IQ_ONE: begin
                  if (instr_retired) begin
                     iq_r <= btir_pkg::BTIR_IQ_IDLE;
                  end
               end
               default: iq_r <= btir_pkg::BTIR_IQ_IDLE;
            endcase
         end
      end
   end
   // vector register: zero for every reset, else the served source
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         vec_r <= `BTIR_VEC_RESET;
      end else if (clk_en) begin
         if (rs_r == btir_pkg::BTIR_RS_CHK) begin
            vec_r <= `BTIR_VEC_RESET;
         end else if (start) begin
            vec_r <= pend_done ? `BTIR_VEC_DONE : `BTIR_VEC_EMPTY;
         end
      end
   end
   assign push_pc = iq_r == btir_pkg::BTIR_IQ_ENTRY;
   assign fetch_vector = iq_r == btir_pkg::BTIR_IQ_JUMP;
   assign pop_pc = iq_r == btir_pkg::BTIR_IQ_RETURN;
   assign vector_addr = vec_r;
   assign tx_key = key_r;
   assign slot_count_low_q = low_r;
   assign slot_control_q = ctrl_r;
   assign flags_q = flags_r;

   ////////////////////////////////////////////////////////////////
   // checks
   entry_four_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      $rose(push_pc) |-> push_pc [*4] ##1 fetch_vector [*2])
      else $error("interrupt entry not four push then two jump");
   jump_two_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      $fell(fetch_vector) |-> $past(fetch_vector, 2))
      else $error("vector jump not two cycles");
   return_four_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      $rose(pop_pc) |-> pop_pc [*4] ##1 !pop_pc)
      else $error("return not four cycles");
   gie_gate_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      $rose(push_pc) |-> $past(global_int_en && instr_boundary))
      else $error("entry without enable or boundary");
   take_flag_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      take && !io_reset |=> flags_q[0] && tx_key == $past(ctrl_r.data))
      else $error("buffer take without flag or key");
   done_vec_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      start && pend_done |=> vector_addr == 10'h002)
      else $error("done vector wrong");
   rx_cap_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      edge_seen && !io_reset |=> slot_count_low_q == $past(cnt_r[7:0])
      && slot_control_q.data == $past(pulse_s))
      else $error("receive capture wrong");
   gen_key_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      is_gen |=> !tx_key)
      else $error("generic mode keyed transmitter");
   noprog_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      rs_r == btir_pkg::BTIR_RS_CHK && reset_word_valid && !jump_word
      && !pin_low && !bo_s && !watchdog_rst |=> no_program && !core_run)
      else $error("missing program not caught");
   serial_two_a: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
      $rose(serial_prog_mode) |-> !serial_io_ready ##2 serial_io_ready)
      else $error("serial access not after two clocks");
endmodule : btir_timer
`default_nettype wire

// ==== tb/bit_timer_with_irq_reset_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module bit_timer_with_irq_reset_bench;
   typedef struct packed {
      logic [2:0] p;
      logic [7:0] lo;
      logic [1:0] hi;
      logic [15:0] ex;
   } btir_row_t;
   logic clk, sys_rst, lo_we, ctl_we, pulse_input_pin, reset_pin_n, button_press;
   logic global_int_en, instr_boundary, instr_retired, reti_req, reset_word_valid;
   logic watchdog_rst, button_rst_req, tx_key, push_pc, pop_pc, fetch_vector;
   logic core_run, io_reset, serial_prog_mode, serial_io_ready, no_program;
   logic key_seen, push_seen;
   logic [7:0] lo_wd, lo_q;
   logic [2:0] pcc, fclr, flags;
   logic [9:0] vector_addr, va;
   logic [15:0] reset_word;
   btir_pkg::btir_ctrl_t ctl_wd, ctl_q;
   int error_cnt, checks, n, g;
   btir_row_t rows [4] = '{{3'h0, 8'h03, 2'h0, 16'h0004}, {3'h1, 8'h02, 2'h0, 16'h0006},
      {3'h0, 8'h00, 2'h1, 16'h0101}, {3'h2, 8'h01, 2'h0, 16'h0008}};
   ////////////////////////////////////////////////////////////////////
   // device and core model; a short power-on wait keeps the run short
   btir_timer #(.POR_DELAY(20)) u_dut (.clk, .sys_rst, .clk_en(1'b1),
      .slot_count_low_we(lo_we), .slot_count_low_wdata(lo_wd), .slot_control_we(ctl_we),
      .slot_control_wdata(ctl_wd), .power_clock_control(pcc), .flag_clr(fclr),
      .slot_count_low_q(lo_q), .slot_control_q(ctl_q), .flags_q(flags), .pulse_input_pin,
      .reset_pin_n, .brownout(1'b0), .button_press, .tx_key, .global_int_en,
      .instr_boundary, .instr_retired, .reti_req, .reset_word, .reset_word_valid,
      .push_pc, .pop_pc, .fetch_vector, .vector_addr, .core_run, .watchdog_rst,
      .button_rst_req, .io_reset, .serial_prog_mode, .serial_io_ready, .no_program);
   btir_core_model u_core (.clk, .sys_rst, .fetch_vector, .pop_pc, .instr_boundary,
      .instr_retired, .reti_req);
   // clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // sticky watchers for things that must never happen in a window
   always @(negedge clk) begin
      if (tx_key === 1'b1) key_seen = 1'b1;
      if (push_pc === 1'b1) push_seen = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one write of both bytes; in transmit mode this also fills the buffer
   task wr(input logic [7:0] lo, input btir_pkg::btir_ctrl_t c);
      lo_wd = lo;
      ctl_wd = c;
      lo_we = 1'b1;
      ctl_we = 1'b1;
      @(negedge clk);
      lo_we = 1'b0;
      ctl_we = 1'b0;
   endtask : wr
   function automatic logic sel(input int k);
      case (k)
         0: return push_pc;
         1: return fetch_vector;
         2: return pop_pc;
         3: return core_run;
         4: return no_program;
         5: return serial_prog_mode;
         default: return serial_io_ready;
      endcase
   endfunction : sel
   // bounded wait for a level, gap in cycles; a hang ends the run
   task wait_on(input int k, output int gap);
      gap = 0;
      while (sel(k) !== 1'b1 && gap < 3000) begin
         @(negedge clk);
         gap++;
      end
      if (gap >= 3000) begin
         chk(32'h0, 32'h1);
         wrap_up;
      end
   endtask : wait_on
   task run_len(input int k, output int len, output int gap);
      wait_on(k, gap);
      va = vector_addr;
      len = 0;
      while (sel(k) === 1'b1 && len < 20) begin
         len++;
         @(negedge clk);
      end
   endtask : run_len
   // wait for a flag, then clear it; cycles counted from entry
   task wait_flag(input int idx, output int cnt);
      cnt = 0;
      while (flags[idx] !== 1'b1 && cnt < 3000) begin
         @(negedge clk);
         cnt++;
      end
      if (cnt >= 3000) begin
         chk(32'h0, 32'h1);
         wrap_up;
      end
      fclr[idx] = 1'b1;
      @(negedge clk);
      fclr = 3'h0;
   endtask : wait_flag
   ////////////////////////////////////////////////////////////////////
   // main sequence, inputs change on falling edges only
   initial begin
      {lo_we, ctl_we, pulse_input_pin, button_press, global_int_en} = 5'h00;
      {watchdog_rst, button_rst_req, key_seen, push_seen} = 4'h0;
      {lo_wd, pcc, fclr, ctl_wd} = 21'h000000;
      error_cnt = 0;
      checks = 0;
      sys_rst = 1'b1;
      reset_pin_n = 1'b1;
      reset_word = 16'h0000;
      reset_word_valid = 1'b1;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      chk(core_run, 1'b0);
      chk(io_reset, 1'b1);
      wait_on(4, g);
      chk(core_run, 1'b0);
      // relative then absolute jump word, each after a watchdog reset
      foreach (rows[i]) if (i < 2) begin
         reset_word = (i == 0) ? 16'hC005 : 16'h940C;
         watchdog_rst = 1'b1;
         @(negedge clk);
         watchdog_rst = 1'b0;
         wait_on(3, g);
         chk(g < 6, 1'b1);
         chk(vector_addr, 10'h000);
      end
      $display("test reset words done");
      // generic timer rows: period between expiries, no keying
      key_seen = 1'b0;
      foreach (rows[i]) begin
         pcc = rows[i].p;
         wr(rows[i].lo, {rows[i].hi, btir_pkg::BTIR_GEN, 3'b000});
         wait_flag(2, n);
         wait_flag(2, n);
         chk(n + 1, rows[i].ex);
      end
      chk(key_seen, 1'b0);
      $display("test generic done");
      // transmit: bits 1 then 0, then an empty buffer
      pcc = 3'h0;
      wr(8'h05, {2'h0, btir_pkg::BTIR_TX, 3'b001});
      wait_flag(0, n);
      chk(tx_key, 1'b1);
      wr(8'h05, {2'h0, btir_pkg::BTIR_TX, 3'b000});
      wait_flag(0, n);
      chk(n + 2, 6);
      chk(tx_key, 1'b0);
      wait_flag(2, n);
      chk(n + 1, 6);
      wr(8'h05, {2'h0, btir_pkg::BTIR_OFF, 3'b000});
      $display("test transmit done");
      // let an edge pass so the strobes are not raised as they drop
      @(negedge clk);
      // receive: two edges thirty cycles apart
      wr(8'h00, {2'h0, btir_pkg::BTIR_RX, 3'b000});
      repeat (10) @(negedge clk);
      pulse_input_pin = 1'b1;
      repeat (30) @(negedge clk);
      chk(ctl_q.data, 1'b1);
      pulse_input_pin = 1'b0;
      repeat (8) @(negedge clk);
      chk(ctl_q.data, 1'b0);
      chk((lo_q === 8'h1E) || (lo_q === 8'h1D), 1'b1);
      $display("test receive done");
      // interrupts: masked, then entry, jump, return and retire gap
      push_seen = 1'b0;
      wr(8'h09, {2'h0, btir_pkg::BTIR_GEN, 3'b100});
      repeat (40) @(negedge clk);
      chk(push_seen, 1'b0);
      global_int_en = 1'b1;
      run_len(0, n, g);
      chk(va, 10'h002);
      chk(n, 4);
      run_len(1, n, g);
      chk(n, 2);
      chk(g, 0);
      run_len(2, n, g);
      chk(n, 4);
      run_len(0, n, g);
      chk(g > 6, 1'b1);
      wr(8'h03, {2'h0, btir_pkg::BTIR_TX, 3'b011});
      run_len(0, n, g);
      chk(va, 10'h004);
      global_int_en = 1'b0;
      $display("test interrupts done");
      // button reset keeps registers, pin reset clears and refuses writes
      wr(8'h5A, {2'h0, btir_pkg::BTIR_OFF, 3'b000});
      button_rst_req = 1'b1;
      @(negedge clk);
      button_rst_req = 1'b0;
      repeat (3) @(negedge clk);
      chk(core_run, 1'b0);
      button_press = 1'b1;
      wait_on(3, g);
      button_press = 1'b0;
      chk(lo_q, 8'h5A);
      reset_pin_n = 1'b0;
      wait_on(5, g);
      wait_on(6, g);
      chk(g, 2);
      wr(8'h77, {2'h0, btir_pkg::BTIR_OFF, 3'b000});
      chk(lo_q, 8'h00);
      reset_pin_n = 1'b1;
      wait_on(3, g);
      $display("test resets done");
      wrap_up;
   end
endmodule : bit_timer_with_irq_reset_bench
`default_nettype wire

// ==== tb/btir_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module btir_core_model (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // sequencing seen from the timer
   input wire logic fetch_vector,
   input wire logic pop_pc,
   // sequencing towards the timer
   output logic instr_boundary,
   output logic instr_retired,
   output logic reti_req
);
   logic fv_r;
   logic pp_r;
   logic [3:0] hnd_r;
   logic [3:0] ret_r;
   logic [1:0] ph_r;
   ////////////////////////////////////////////////////////////////////
   // handler: requests its return after a fixed length
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fv_r <= 1'b0;
         hnd_r <= 4'h0;
         reti_req <= 1'b0;
      end else begin
         fv_r <= fetch_vector;
         reti_req <= (hnd_r == 4'h1);
         if (fv_r && !fetch_vector) begin
            hnd_r <= 4'h6;
         end else if (hnd_r != 4'h0) begin
            hnd_r <= hnd_r - 4'h1;
         end
      end
   end
   // main program retires late after a return, so a pending
   // interrupt must visibly wait for it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pp_r <= 1'b0;
         ret_r <= 4'h0;
         instr_retired <= 1'b0;
      end else begin
         pp_r <= pop_pc;
         instr_retired <= (ret_r == 4'h1);
         if (pp_r && !pop_pc) begin
            ret_r <= 4'h8;
         end else if (ret_r != 4'h0) begin
            ret_r <= ret_r - 4'h1;
         end
      end
   end
   // three-cycle instructions: only the last cycle may be interrupted
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ph_r <= 2'h0;
      end else begin
         ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      end
   end
   assign instr_boundary = (ph_r == 2'h2);
endmodule : btir_core_model
`default_nettype wire
